/* File: rtl/bgo_device.sv */
// Display end: command interpreter for bar graphs and general outputs
`timescale 1ns/10ps
module bgo_device
  import bgo_pkg::*;
#(
  parameter int GO_NUM = `BGO_GO_NUM
)
(
  input  wire logic              clock,
  input  wire logic              sys_rst,
  bgo_link_if.dev                lnk,
  input  wire logic [GO_NUM-1:0] nv_image,
  input  wire logic [6:0]        rd_cell,
  output logic [7:0]             rd_char,
  output bgo_bank_t              active_bank,
  output logic                   bank_load,
  output logic [GO_NUM-1:0]      general_output,
  output logic                   nv_we,
  output logic [GO_NUM-1:0]      nv_wdata,
  output logic                   char_valid,
  output logic [7:0]             char_data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bgo_pstate_t        st;
    logic [7:0]         cmd;
    logic [2:0]         need;
    logic [2:0]         pcnt;
    logic [3:0][7:0]    par;
    logic [79:0][7:0]   cells;
    bgo_bank_t          bank;
    logic               bank_load;
    logic [GO_NUM-1:0]  go;
    logic [GO_NUM-1:0]  nv;
    logic               nv_we;
    logic               init_done;
    logic               ch_v;
    logic [7:0]         ch_d;
    logic [7:0]         rd_char;
    logic [5:0]         col;
    logic [2:0]         row;
    logic [6:0]         rem;
    logic               dir;
  } bgo_dev_t;

  bgo_dev_t s_ff;
  bgo_dev_t nxt_s;
  logic [6:0] seg;

  function automatic logic [6:0] bgo_cell_idx(input logic [2:0] row, input logic [5:0] col);
    logic [6:0] r;
    r = 7'(row - 3'h1);
    return 7'(r * 7'(`BGO_COLS) + 7'(col) - 7'h01);
  endfunction : bgo_cell_idx

  // ----------------------------------------------------------------
  // Interpreter
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_s           = s_ff;
    nxt_s.bank_load = 1'b0;
    nxt_s.nv_we     = 1'b0;
    nxt_s.ch_v      = 1'b0;
    seg             = (s_ff.rem > `BGO_CELL_W) ? `BGO_CELL_W : s_ff.rem;
    nxt_s.rd_char   = (rd_cell < `BGO_CELLS) ? s_ff.cells[rd_cell] : 8'h00;
    if (!s_ff.init_done)
    begin
      // Saved states are only looked at once, after reset release
      nxt_s.init_done = 1'b1;
      nxt_s.go        = nv_image;
      nxt_s.nv        = nv_image;
    end
    unique case (s_ff.st)
      BGO_IDLE:
        if (s_ff.init_done && lnk.valid)
        begin
          if (lnk.data == `BGO_PREFIX)
            nxt_s.st = BGO_CMD;
          else
          begin
            nxt_s.ch_v = 1'b1;
            nxt_s.ch_d = lnk.data;
          end
        end
      BGO_CMD:
        if (lnk.valid)
        begin
          nxt_s.cmd  = lnk.data;
          nxt_s.pcnt = 3'h0;
          nxt_s.need = bgo_nparams(lnk.data);
          nxt_s.st   = (bgo_nparams(lnk.data) == 3'h0) ? BGO_IDLE : BGO_PARAM;
          if (lnk.data == `BGO_CMD_HBANK || lnk.data == `BGO_CMD_NBANK ||
              lnk.data == `BGO_CMD_WBANK)
            nxt_s.bank_load = 1'b1;
          if (lnk.data == `BGO_CMD_HBANK)
            nxt_s.bank = BGO_BANK_HBAR;
          if (lnk.data == `BGO_CMD_NBANK)
            nxt_s.bank = BGO_BANK_NARROW;
          if (lnk.data == `BGO_CMD_WBANK)
            nxt_s.bank = BGO_BANK_WIDE;
        end
      BGO_PARAM:
        if (lnk.valid)
        begin
          nxt_s.par[s_ff.pcnt[1:0]] = lnk.data;
          nxt_s.pcnt = 3'(s_ff.pcnt + 3'h1);
          if (s_ff.pcnt == 3'(s_ff.need - 3'h1))
            nxt_s.st = BGO_EXEC;
        end
      BGO_EXEC:
      begin
        nxt_s.st = BGO_IDLE;
        unique case (s_ff.cmd)
          `BGO_CMD_HBAR:
            // Column, row, direction, length
            if (s_ff.par[0] >= 8'h01 && s_ff.par[0] <= `BGO_COLS &&
                s_ff.par[1] >= 8'h01 && s_ff.par[1] <= `BGO_ROWS &&
                s_ff.par[2] <= 8'h01 && s_ff.par[3] <= `BGO_HLEN_MAX)
            begin
              nxt_s.col = s_ff.par[0][5:0];
              nxt_s.row = s_ff.par[1][2:0];
              nxt_s.dir = s_ff.par[2][0];
              nxt_s.rem = s_ff.par[3][6:0];
              nxt_s.st  = BGO_DRAW_H;
            end
          `BGO_CMD_VBAR:
            if (s_ff.par[0] >= 8'h01 && s_ff.par[0] <= `BGO_COLS &&
                s_ff.par[1] <= `BGO_VLEN_MAX)
            begin
              nxt_s.col = s_ff.par[0][5:0];
              nxt_s.row = 3'(`BGO_ROWS);
              nxt_s.rem = s_ff.par[1][6:0];
              nxt_s.st  = BGO_DRAW_V;
            end
          `BGO_CMD_GO_ON, `BGO_CMD_GO_OFF:
            for (int i = 0; i < GO_NUM; i++)
              if (s_ff.par[0] == 8'(i + 1))
                nxt_s.go[i] = (s_ff.cmd == `BGO_CMD_GO_ON);
          `BGO_CMD_GO_PWRUP:
            if (s_ff.par[1] <= 8'h01)
              for (int i = 0; i < GO_NUM; i++)
                if (s_ff.par[0] == 8'(i + 1))
                begin
                  nxt_s.nv[i] = s_ff.par[1][0];
                  nxt_s.nv_we = 1'b1;
                end
          default:
            nxt_s.st = BGO_IDLE;
        endcase
      end
      BGO_DRAW_H:
        // One cell per cycle; the bar is clipped at the screen edge
        if (s_ff.rem == 7'h00 || s_ff.col == 6'h00 || s_ff.col > 6'(`BGO_COLS))
          nxt_s.st = BGO_IDLE;
        else
        begin
          nxt_s.cells[bgo_cell_idx(s_ff.row, s_ff.col)] = 8'(seg - 7'h01);
          nxt_s.rem = 7'(s_ff.rem - seg);
          nxt_s.col = s_ff.dir ? 6'(s_ff.col - 6'h01) : 6'(s_ff.col + 6'h01);
        end
      BGO_DRAW_V:
      begin
        // Every row of the column is rewritten, so no old bar survives
        if (s_ff.rem == 7'h00)
          nxt_s.cells[bgo_cell_idx(s_ff.row, s_ff.col)] = `BGO_BLANK;
        else if (s_ff.rem >= `BGO_CELL_H)
          nxt_s.cells[bgo_cell_idx(s_ff.row, s_ff.col)] = 8'(`BGO_CELL_H - 7'h01);
        else
          nxt_s.cells[bgo_cell_idx(s_ff.row, s_ff.col)] = 8'(s_ff.rem - 7'h01);
        nxt_s.rem = (s_ff.rem >= `BGO_CELL_H) ? 7'(s_ff.rem - `BGO_CELL_H) : 7'h00;
        nxt_s.row = 3'(s_ff.row - 3'h1);
        if (s_ff.row == 3'h1)
          nxt_s.st = BGO_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_ff       <= '0;
      s_ff.st    <= BGO_IDLE;
      s_ff.bank  <= BGO_BANK_NONE;
      s_ff.cells <= {80{`BGO_BLANK}};
    end
    else
      s_ff <= nxt_s;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Drawing stalls the link, so no byte is lost while cells are written
  assign lnk.ready      = s_ff.init_done &&
                          (s_ff.st == BGO_IDLE || s_ff.st == BGO_CMD || s_ff.st == BGO_PARAM);
  assign rd_char        = s_ff.rd_char;
  assign active_bank    = s_ff.bank;
  assign bank_load      = s_ff.bank_load;
  assign general_output = s_ff.go;
  assign nv_we          = s_ff.nv_we;
  assign nv_wdata       = s_ff.nv;
  assign char_valid     = s_ff.ch_v;
  assign char_data      = s_ff.ch_d;

endmodule : bgo_device

/* File: rtl/bgo_map.svh */
// Constants of the bar graph and general output command link
//
// Behaviour
// - Prefix then 104 loads horizontal bar bank
// - Host loads matching bank before placing bars
// - Command 124: column, row, direction, length bytes
// - Horizontal start column within 1 to 20
// - Horizontal start row within 1 to 4
// - Direction 0 grows right, 1 grows left
// - Horizontal length 0 to 100, exact pixels
// - New horizontal bar replaces covered cells
// - Command 115 loads narrow two-pixel bar bank
// - Command 118 loads wide five-pixel bar bank
// - Command 61: column, length; bar rises upward
// - Vertical bar column within 1 to 20
// - Vertical height 0 to 32, exact pixels
// - New vertical bar replaces column's old bar
// - Command 87 with number drives output high
// - Command 86 with number drives output low
// - Command 195 stores output power-up state
// - State byte 1 means on, 0 off
// - Stored state applies only at next power-up
// - Bank load discards unsaved custom glyphs
`ifndef BGO_MAP_SVH
`define BGO_MAP_SVH

// ----------------------------------------------------------------
// Command bytes
// ----------------------------------------------------------------
`define BGO_PREFIX       8'hfe
`define BGO_CMD_HBANK    8'h68
`define BGO_CMD_NBANK    8'h73
`define BGO_CMD_WBANK    8'h76
`define BGO_CMD_HBAR     8'h7c
`define BGO_CMD_VBAR     8'h3d
`define BGO_CMD_GO_ON    8'h57
`define BGO_CMD_GO_OFF   8'h56
`define BGO_CMD_GO_PWRUP 8'hc3

// ----------------------------------------------------------------
// Parameter byte counts
// ----------------------------------------------------------------
`define BGO_NP_HBAR      3'h4
`define BGO_NP_VBAR      3'h2
`define BGO_NP_GO        3'h1
`define BGO_NP_PWRUP     3'h2
`define BGO_NP_NONE      3'h0

// ----------------------------------------------------------------
// Screen geometry and ranges
// ----------------------------------------------------------------
`define BGO_COLS         8'h14
`define BGO_ROWS         8'h04
`define BGO_CELLS        7'h50
`define BGO_HLEN_MAX     8'h64
`define BGO_VLEN_MAX     8'h20
`define BGO_CELL_W       7'h05
`define BGO_CELL_H       7'h08
`define BGO_BLANK        8'h20
`define BGO_GO_NUM       6

// ----------------------------------------------------------------
// Host controller registers
// ----------------------------------------------------------------
`define BGO_REG_CMD      8'h00
`define BGO_REG_PARAM    8'h04
`define BGO_REG_STATUS   8'h08
`define BGO_ST_BUSY      0
`define BGO_ST_REFUSED   1
`define BGO_ST_BANK_LO   2

`endif

/* File: rtl/bgo_pkg.sv */
// Types shared by both ends of the bar graph command link
package bgo_pkg;
  `include "bgo_map.svh"

  typedef enum logic [2:0] {
    BGO_IDLE,
    BGO_CMD,
    BGO_PARAM,
    BGO_EXEC,
    BGO_DRAW_H,
    BGO_DRAW_V
  } bgo_pstate_t;

  typedef enum logic [1:0] {
    BGO_BANK_NONE,
    BGO_BANK_HBAR,
    BGO_BANK_NARROW,
    BGO_BANK_WIDE
  } bgo_bank_t;

  // Parameter bytes following each command byte; unknown ones take none
  function automatic logic [2:0] bgo_nparams(input logic [7:0] cmd);
    unique case (cmd)
      `BGO_CMD_HBAR:     return `BGO_NP_HBAR;
      `BGO_CMD_VBAR:     return `BGO_NP_VBAR;
      `BGO_CMD_GO_ON:    return `BGO_NP_GO;
      `BGO_CMD_GO_OFF:   return `BGO_NP_GO;
      `BGO_CMD_GO_PWRUP: return `BGO_NP_PWRUP;
      default:           return `BGO_NP_NONE;
    endcase
  endfunction : bgo_nparams
endpackage : bgo_pkg

/* File: rtl/bgo_link_if.sv */
// Byte link between host controller and display command interpreter
`timescale 1ns/10ps
interface bgo_link_if;
  logic [7:0] data;
  logic       valid;
  logic       ready;

  modport dev  (input data, input valid, output ready);
  modport host (output data, output valid, input ready);
endinterface : bgo_link_if

/* File: rtl/bgo_host.sv */
// Host end: AHB-Lite controlled sender of bar graph and output commands
`timescale 1ns/10ps
module bgo_host
  import bgo_pkg::*;
#(
  parameter int GO_NUM = `BGO_GO_NUM
)
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  bgo_link_if.host         lnk
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic            ap_v;
    logic            ap_wr;
    logic [7:0]      ap_addr;
    logic [31:0]     rdata;
    logic [7:0]      cmd;
    logic [3:0][7:0] par;
    logic            busy;
    logic            refused;
    bgo_bank_t       bank;
    logic [5:0][7:0] seq;
    logic [2:0]      len;
    logic [2:0]      idx;
    logic            vld;
    logic [7:0]      dat;
  } bgo_host_t;

  bgo_host_t  s_ff;
  bgo_host_t  nxt_s;
  logic       ok;
  logic       set_ref;
  logic [7:0] wcmd;
  logic [31:0] status;

  always_comb
  begin
    nxt_s   = s_ff;
    set_ref = 1'b0;
    wcmd    = hwdata[7:0];
    status  = {28'h0, s_ff.bank, s_ff.refused, s_ff.busy};
    // Order checks; a placement needs its bank loaded first
    unique case (wcmd)
      `BGO_CMD_HBANK, `BGO_CMD_NBANK, `BGO_CMD_WBANK:
        ok = 1'b1;
      `BGO_CMD_HBAR:
        ok = s_ff.bank == BGO_BANK_HBAR &&
             s_ff.par[0] >= 8'h01 && s_ff.par[0] <= `BGO_COLS &&
             s_ff.par[1] >= 8'h01 && s_ff.par[1] <= `BGO_ROWS &&
             s_ff.par[2] <= 8'h01 && s_ff.par[3] <= `BGO_HLEN_MAX;
      `BGO_CMD_VBAR:
        ok = (s_ff.bank == BGO_BANK_NARROW || s_ff.bank == BGO_BANK_WIDE) &&
             s_ff.par[0] >= 8'h01 && s_ff.par[0] <= `BGO_COLS &&
             s_ff.par[1] <= `BGO_VLEN_MAX;
      `BGO_CMD_GO_ON, `BGO_CMD_GO_OFF:
        ok = s_ff.par[0] >= 8'h01 && s_ff.par[0] <= 8'(GO_NUM);
      `BGO_CMD_GO_PWRUP:
        ok = s_ff.par[0] >= 8'h01 && s_ff.par[0] <= 8'(GO_NUM) &&
             s_ff.par[1] <= 8'h01;
      default:
        ok = 1'b0;
    endcase

    // ----------------------------------------------------------------
    // Bus address phase; zero wait states, read data in the data phase
    // ----------------------------------------------------------------
    nxt_s.ap_v = hsel && hready && htrans[1];
    if (hsel && hready && htrans[1])
    begin
      nxt_s.ap_wr   = hwrite;
      nxt_s.ap_addr = haddr[7:0];
      unique case (haddr[7:0])
        `BGO_REG_CMD:    nxt_s.rdata = {24'h0, s_ff.cmd};
        `BGO_REG_PARAM:  nxt_s.rdata = s_ff.par;
        `BGO_REG_STATUS: nxt_s.rdata = status;
        default:         nxt_s.rdata = 32'h0;
      endcase
    end

    // ----------------------------------------------------------------
    // Link sender
    // ----------------------------------------------------------------
    if (s_ff.vld && lnk.ready)
    begin
      if (s_ff.idx == 3'(s_ff.len - 3'h1))
      begin
        nxt_s.vld  = 1'b0;
        nxt_s.busy = 1'b0;
      end
      else
      begin
        nxt_s.idx = 3'(s_ff.idx + 3'h1);
        nxt_s.dat = s_ff.seq[3'(s_ff.idx + 3'h1)];
      end
    end

    // ----------------------------------------------------------------
    // Bus data phase writes
    // ----------------------------------------------------------------
    if (s_ff.ap_v && s_ff.ap_wr)
    begin
      unique case (s_ff.ap_addr)
        `BGO_REG_PARAM:
          nxt_s.par = hwdata;
        `BGO_REG_CMD:
          if (s_ff.busy || !ok)
            set_ref = 1'b1;
          else
          begin
            nxt_s.cmd  = wcmd;
            nxt_s.seq  = {s_ff.par, wcmd, `BGO_PREFIX};
            nxt_s.len  = 3'(bgo_nparams(wcmd) + 3'h2);
            nxt_s.idx  = 3'h0;
            nxt_s.dat  = `BGO_PREFIX;
            nxt_s.vld  = 1'b1;
            nxt_s.busy = 1'b1;
            if (wcmd == `BGO_CMD_HBANK)
              nxt_s.bank = BGO_BANK_HBAR;
            if (wcmd == `BGO_CMD_NBANK)
              nxt_s.bank = BGO_BANK_NARROW;
            if (wcmd == `BGO_CMD_WBANK)
              nxt_s.bank = BGO_BANK_WIDE;
          end
        `BGO_REG_STATUS:
          if (hwdata[`BGO_ST_REFUSED])
            nxt_s.refused = 1'b0;
        default:
          nxt_s.refused = s_ff.refused;
      endcase
    end
    // A refusal in the same cycle as its clear still shows
    if (set_ref)
      nxt_s.refused = 1'b1;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_ff      <= '0;
      s_ff.bank <= BGO_BANK_NONE;
    end
    else
      s_ff <= nxt_s;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_ff.rdata;
  assign lnk.valid = s_ff.vld;
  assign lnk.data  = s_ff.dat;

endmodule : bgo_host

/* File: bench/bgo_link_sva.sv */
// Framing and handshake checks on the bar graph command link
`timescale 1ns/10ps
`include "bgo_map.svh"
module bgo_link_sva
(
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic [7:0] data,
  input wire logic       valid,
  input wire logic       ready
);
  // ----------------------------------------------------------------
  // Frame tracking
  // ----------------------------------------------------------------
  logic [2:0] pos_ff;
  logic [7:0] cmd_ff;
  logic [2:0] np;
  logic       take;
  logic       fin;
  logic       plast;
  function automatic logic [2:0] npar(input logic [7:0] c);
    case (c)
      `BGO_CMD_HBAR:                    return 3'h4;
      `BGO_CMD_VBAR, `BGO_CMD_GO_PWRUP: return 3'h2;
      `BGO_CMD_GO_ON, `BGO_CMD_GO_OFF:  return 3'h1;
      default:                          return 3'h0;
    endcase
  endfunction : npar
  assign np    = npar(cmd_ff);
  assign take  = valid && ready;
  assign plast = take && pos_ff >= 3'h2 && pos_ff == np + 3'h1;
  // Bank loads carry no parameters, so their frame ends at the command byte
  assign fin   = plast || (take && pos_ff == 3'h1 && npar(data) == 3'h0);
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      pos_ff <= 3'h0;
    else if (take)
      pos_ff <= fin ? 3'h0 : pos_ff + 3'h1;
  end
  always_ff @(posedge clock)
  begin
    if (take && pos_ff == 3'h1)
      cmd_ff <= data;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  hold_valid_a: assert property (valid && !ready |=> valid)
    else $error("valid dropped before take");
  hold_data_a: assert property (valid && !ready |=> $stable(data))
    else $error("data changed before take");
  prefix_first_a: assert property (valid && pos_ff == 3'h0 |-> data == `BGO_PREFIX)
    else $error("frame without prefix");
  hcol_range_a: assert property (take && pos_ff == 3'h2 && cmd_ff == `BGO_CMD_HBAR
    |-> data inside {[8'h01:8'h14]}) else $error("bad hbar column");
  hrow_range_a: assert property (take && pos_ff == 3'h3 && cmd_ff == `BGO_CMD_HBAR
    |-> data inside {[8'h01:8'h04]}) else $error("bad hbar row");
  hlen_range_a: assert property (take && pos_ff == 3'h5 && cmd_ff == `BGO_CMD_HBAR
    |-> data <= 8'h64) else $error("bad hbar length");
  vcol_range_a: assert property (take && pos_ff == 3'h2 && cmd_ff == `BGO_CMD_VBAR
    |-> data inside {[8'h01:8'h14]}) else $error("bad vbar column");
  vlen_range_a: assert property (take && pos_ff == 3'h3 && cmd_ff == `BGO_CMD_VBAR
    |-> data <= 8'h20) else $error("bad vbar height");
  pwr_state_a: assert property (take && pos_ff == 3'h3 && cmd_ff == `BGO_CMD_GO_PWRUP
    |-> data <= 8'h01) else $error("bad power-up state");
  exec_stall_a: assert property (plast |=> !ready)
    else $error("byte accepted during execute");
  vbar_draw_a: assert property (plast && cmd_ff == `BGO_CMD_VBAR
    |=> !ready [*5] ##1 ready) else $error("vbar draw time wrong");
endmodule : bgo_link_sva

/* File: bench/test_bar_graph_and_output_commands.sv */
// Bench joining host and device ends, checked against a screen model
`timescale 1ns/10ps
`include "bgo_map.svh"
module test_bar_graph_and_output_commands
  import bgo_pkg::*;
;
  logic clock, sys_rst, hsel, hwrite, hready, hreadyout, hresp, bank_load, nv_we, char_valid;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [5:0]  nv_image, general_output, nv_wdata, go_m, img_m;
  logic [6:0]  rd_cell;
  logic [7:0]  rd_char, char_data, rnd;
  bgo_bank_t   active_bank;
  int          scr[80];
  int          bank_m, loads_m = 0, nvw_m = 0, loads = 0, nvws = 0, chars = 0;
  int          checks = 0, miscompares = 0;
  bgo_link_if lnk();
  bgo_host i_bgo_host (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .lnk(lnk));
  bgo_device i_bgo_device (.clock(clock), .sys_rst(sys_rst), .lnk(lnk), .nv_image(nv_image),
    .rd_cell(rd_cell), .rd_char(rd_char), .active_bank(active_bank), .bank_load(bank_load),
    .general_output(general_output), .nv_we(nv_we), .nv_wdata(nv_wdata),
    .char_valid(char_valid), .char_data(char_data));
  bgo_link_sva i_bgo_link_sva (.clock(clock), .sys_rst(sys_rst), .data(lnk.data),
    .valid(lnk.valid), .ready(lnk.ready));
  assign hready = hreadyout;
  always #5 clock = ~clock;
  // Pulses are counted here because the tasks never sit on the edge that shows them
  always @(posedge clock)
  begin
    loads <= loads + int'(bank_load === 1'b1);
    nvws <= nvws + int'(nv_we === 1'b1);
    chars <= chars + int'(char_valid === 1'b1);
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic note(input string s);
    $display("test %s done", s);
  endtask : note
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  function automatic int nxt(input int m);
    rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
    return int'(rnd) % m;
  endfunction : nxt
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do
      @(posedge clock);
    while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do
      @(posedge clock);
    while (hready !== 1'b1);
    q = hrdata;
  endtask : ahb
  task automatic send(input logic [7:0] c, input logic [31:0] p, input bit ok);
    ahb(1'b1, {24'h0, `BGO_REG_PARAM}, p, r);
    ahb(1'b1, {24'h0, `BGO_REG_CMD}, {24'h0, c}, r);
    r = 32'h1;
    while (r[0] !== 1'b0)
      ahb(1'b0, {24'h0, `BGO_REG_STATUS}, 32'h0, r);
    while (lnk.ready !== 1'b1)
      @(posedge clock);
    // One more edge so the pulse counters have taken the last effect
    @(posedge clock);
    chk("refused", {31'h0, !ok}, {31'h0, r[1]});
    if (!ok)
      ahb(1'b1, {24'h0, `BGO_REG_STATUS}, 32'h2, r);
  endtask : send
  task automatic do_reset(input logic [5:0] img);
    sys_rst <= 1'b1;
    nv_image <= img;
    repeat (16)
      @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2)
      @(posedge clock);
    go_m = img;
    img_m = img;
    bank_m = 0;
    scr = '{default: 32};
    chk("outputs", 32'(go_m), 32'(general_output));
    chk("image", 32'(img_m), 32'(nv_wdata));
  endtask : do_reset
  task automatic screen();
    for (int i = 0; i < 80; i++)
    begin
      rd_cell <= 7'(i);
      repeat (2)
        @(posedge clock);
      chk("cell", 32'(scr[i]), {24'h0, rd_char});
    end
  endtask : screen
  task automatic bank(input logic [7:0] c, input int b);
    send(c, 32'h0, 1'b1);
    bank_m = b;
    loads_m++;
    chk("bank", 32'(b), 32'(active_bank));
    chk("bank bits", 32'(b), {30'h0, r[3:2]});
    chk("loads", 32'(loads_m), 32'(loads));
  endtask : bank
  task automatic hbar(input int c, input int w, input int d, input int n);
    bit ok;
    int x;
    ok = bank_m == 1 && c >= 1 && c <= 20 && w >= 1 && w <= 4 && d <= 1 && n <= 100;
    send(`BGO_CMD_HBAR, {8'(n), 8'(d), 8'(w), 8'(c)}, ok);
    for (int k = 0; ok && k < (n + 4) / 5; k++)
    begin
      x = d == 1 ? c - 1 - k : c - 1 + k;
      if (x >= 0 && x < 20)
        scr[(w - 1) * 20 + x] = n - 5 * k >= 5 ? 4 : n - 5 * k - 1;
    end
  endtask : hbar
  task automatic vbar(input int c, input int n);
    bit ok;
    ok = bank_m >= 2 && c >= 1 && c <= 20 && n <= 32;
    send(`BGO_CMD_VBAR, {16'h0, 8'(n), 8'(c)}, ok);
    for (int k = 0; ok && k < 4; k++)
      scr[(3 - k) * 20 + c - 1] = n - 8 * k <= 0 ? 32 : (n - 8 * k >= 8 ? 7 : n - 8 * k - 1);
  endtask : vbar
  task automatic go(input logic [7:0] c, input int n, input int s);
    bit ok;
    ok = n >= 1 && n <= 6 && (c != `BGO_CMD_GO_PWRUP || s <= 1);
    send(c, {16'h0, 8'(s), 8'(n)}, ok);
    if (ok && c == `BGO_CMD_GO_PWRUP)
    begin
      img_m[n - 1] = s[0];
      nvw_m++;
    end
    else if (ok)
      go_m[n - 1] = c == `BGO_CMD_GO_ON;
    chk("outputs", 32'(go_m), 32'(general_output));
    chk("image", 32'(img_m), 32'(nv_wdata));
    chk("stores", 32'(nvw_m), 32'(nvws));
  endtask : go
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (60000)
      @(posedge clock);
    miscompares++;
    test_done();
  end
  initial
  begin
    clock = 1'b0;
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    nv_image = 6'h0;
    rd_cell = 7'h0;
    rnd = 8'h54;
    do_reset(6'(nxt(64)));
    screen();
    ahb(1'b0, 32'h10, 32'h0, r);
    chk("unmapped", 32'h0, r);
    rd_cell <= 7'h50;
    repeat (2)
      @(posedge clock);
    chk("far cell", 32'h0, {24'h0, rd_char});
    note("reset");
    hbar(3, 2, 0, 12);
    bank(`BGO_CMD_HBANK, 1);
    hbar(3, 2, 0, 12);
    hbar(2, 1, 1, 100);
    hbar(17, 4, 0, 100);
    hbar(4, 2, 1, 7);
    hbar(9, 3, 0, 0);
    hbar(21, 1, 0, 5);
    hbar(1, 5, 1, 5);
    hbar(1, 1, 2, 101);
    repeat (4)
      hbar(nxt(20) + 1, nxt(4) + 1, nxt(2), nxt(101));
    screen();
    note("horizontal");
    vbar(2, 5);
    bank(`BGO_CMD_NBANK, 2);
    vbar(1, 32);
    bank(`BGO_CMD_WBANK, 3);
    vbar(1, 13);
    vbar(20, 0);
    vbar(21, 4);
    vbar(3, 33);
    repeat (3)
      vbar(nxt(20) + 1, nxt(33));
    screen();
    ahb(1'b0, {24'h0, `BGO_REG_CMD}, 32'h0, r);
    chk("last code", {24'h0, `BGO_CMD_VBAR}, r);
    note("vertical");
    bank(`BGO_CMD_HBANK, 1);
    for (int n = 0; n <= 7; n++)
      go(`BGO_CMD_GO_ON, n, 0);
    for (int n = 1; n <= 6; n += 2)
      go(`BGO_CMD_GO_OFF, n, 0);
    go(`BGO_CMD_GO_PWRUP, 2, int'(!img_m[1]));
    go(`BGO_CMD_GO_PWRUP, 5, int'(!img_m[4]));
    go(`BGO_CMD_GO_PWRUP, 3, 2);
    do_reset(img_m);
    chk("chars", 32'h0, 32'(chars));
    chk("char byte", 32'h0, {24'h0, char_data});
    chk("okay", 32'h0, {31'h0, hresp});
    note("outputs");
    test_done();
  end
endmodule : test_bar_graph_and_output_commands
